/* include/wide_bus_pkg.sv */
`include "wide_bus_regs.svh"

package wide_bus_pkg;

  typedef logic [`WBR_HALF_W-1:0] half_word_t;
  typedef logic [`WBR_DATA_W-1:0] full_word_t;
  typedef logic [1:0]             settle_cnt_t;

endpackage

/* include/wide_bus_regs.svh */
`ifndef WIDE_BUS_REGS_SVH
`define WIDE_BUS_REGS_SVH

// Width of one independently enabled half.
`define WBR_HALF_W 10
// Width of the whole register.
`define WBR_DATA_W 20
// Lowest bit of the upper half.
`define WBR_HI_LSB 10
// Flip-flops from a pin to the stored value.
`define WBR_PIPE_DEPTH 2'h3
// Level of an active-low enable that floats the outputs.
`define WBR_OE_N_OFF 1'b1
// Value of an output enable that releases the pins.
`define WBR_DRIVE_OFF 1'b0
// Start value of the settle counter.
`define WBR_SETTLE_ZERO 2'h0
// Step of the settle counter.
`define WBR_SETTLE_STEP 2'h1

`endif

/* tb/bus_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wide_bus_regs.svh"

module bus_far_end
  import wide_bus_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire full_word_t q_i,
  input  wire full_word_t q_oe_i,
  output var  full_word_t bus_o
);
  full_word_t last_q;

  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < `WBR_DATA_W; i++) begin
      if (q_oe_i[i]) begin
        last_q[i] <= q_i[i];
      end
    end
  end

  // A released line shows the inverse of its last driven level.
  always_comb begin
    for (int i = 0; i < `WBR_DATA_W; i++) begin
      bus_o[i] = q_oe_i[i] ? q_i[i] : ~last_q[i];
    end
  end
endmodule

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wide_bus_regs.svh"

`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  num_errors++; $display("ERROR %s exp %h got %h", nm, ex, got); end end

module tb_top
  import wide_bus_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn;
  full_word_t  d;
  logic        oe_lo_n;
  logic        oe_hi_n;
  full_word_t  q;
  full_word_t  q_oe;
  full_word_t  bus;
  full_word_t  e;
  full_word_t  d_hist [3];
  logic [1:0]  oe_hist [3];
  logic [2:0]  rst_hist;
  logic [31:0] lfsr;
  int          filled;
  int          num_errors = 0;
  int          check_count = 0;

  always #20 clk = ~clk;

  wide_bus_register wide_bus_register_i (
    .sys_clk_i (clk),
    .resetn_i  (rstn),
    .d_i       (d),
    .oe_lo_n_i (oe_lo_n),
    .oe_hi_n_i (oe_hi_n),
    .q_o       (q),
    .q_oe_o    (q_oe)
  );

  bus_far_end bus_far_end_i (
    .sys_clk_i (clk),
    .q_i       (q),
    .q_oe_i    (q_oe),
    .bus_o     (bus)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic full_word_t exp_oe(input logic [1:0] en);
    return {{`WBR_HALF_W{en[1]}}, {`WBR_HALF_W{en[0]}}};
  endfunction

  task automatic stop_test;
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    d = '0;
    oe_lo_n = 1'b1;
    oe_hi_n = 1'b1;
    lfsr = 32'ha2a6;
    filled = 0;
    rst_hist = 3'h0;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (filled >= 3) begin
        e = (rst_hist != 3'h7) ? '0 : exp_oe(oe_hist[2]);
        `CHK("q_o", d_hist[2], q)
        `CHK("q_oe_o", e, q_oe)
        `CHK("bus", d_hist[2] & e, bus & e)
      end
      lfsr = lfsr_next(lfsr);
      rstn = !(i < 16 || (i >= 200 && i < 205));
      d = lfsr[19:0];
      oe_lo_n = lfsr[20];
      oe_hi_n = lfsr[21];
      if (i >= 60 && i < 90) begin
        oe_lo_n = 1'b1;
      end
      if (i >= 120 && i < 140) begin
        oe_hi_n = 1'b1;
        oe_lo_n = 1'b1;
      end
      if (!rstn) begin
        oe_lo_n = 1'b1;
        oe_hi_n = 1'b1;
      end
      d_hist[2] = d_hist[1];
      d_hist[1] = d_hist[0];
      d_hist[0] = d;
      oe_hist[2] = oe_hist[1];
      oe_hist[1] = oe_hist[0];
      oe_hist[0] = ~{oe_hi_n, oe_lo_n};
      rst_hist = {rst_hist[1:0], rstn};
      filled++;
    end
    stop_test();
  end
endmodule

`default_nettype wire

/* verilog/wide_bus_half.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wide_bus_regs.svh"

module wide_bus_half
  import wide_bus_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire half_word_t data_i,
  input  wire logic       oe_n_i,
  output var  half_word_t q_o,
  output var  half_word_t q_oe_o
);

  half_word_t store_d;
  half_word_t oe_d;

  // Storage loads every edge, whatever the enable and the reset. [R01] [R04]
  always_comb begin
    store_d = data_i; // [R01] [R07]
  end

  always_ff @(posedge sys_clk_i) begin
    q_o <= store_d;
  end

  // The enable steers only the pin drivers of this half. [R03] [R05]
  always_comb begin
    oe_d = {`WBR_HALF_W{~oe_n_i}}; // [R03]
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      q_oe_o <= {`WBR_HALF_W{`WBR_DRIVE_OFF}}; // [R06]
    end else begin
      q_oe_o <= oe_d;
    end
  end

endmodule

`default_nettype wire

/* verilog/wide_bus_register.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wide_bus_regs.svh"

// Functional notes
// R01 - Every clock edge stores all twenty inputs.
// R02 - Two ten-bit halves, each separately enabled.
// R03 - Enable low drives half; high floats it.
// R04 - Enable never stops or alters storage.
// R05 - Re-enabled half shows its current contents.
// R06 - Controller holds enables high at power.
// R07 - Storage has no reset; undefined until loaded.
module wide_bus_register
  import wide_bus_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire full_word_t d_i,
  input  wire logic       oe_lo_n_i,
  input  wire logic       oe_hi_n_i,
  output var  full_word_t q_o,
  output var  full_word_t q_oe_o
);

  full_word_t  data_meta_q;
  full_word_t  data_sync_q;
  full_word_t  data_meta_d;
  full_word_t  data_sync_d;
  logic        oe_lo_meta_q;
  logic        oe_lo_sync_q;
  logic        oe_hi_meta_q;
  logic        oe_hi_sync_q;
  logic        oe_lo_meta_d;
  logic        oe_lo_sync_d;
  logic        oe_hi_meta_d;
  logic        oe_hi_sync_d;
  settle_cnt_t settle_q;
  settle_cnt_t settle_d;
  logic        settled;

  // Data pins pass two flip-flops; no reset so storage keeps loading.
  always_comb begin
    data_meta_d = d_i;
    data_sync_d = data_meta_q;
  end

  always_ff @(posedge sys_clk_i) begin
    data_meta_q <= data_meta_d;
    data_sync_q <= data_sync_d; // [R07]
  end

  // Enable pins pass two flip-flops and reset to the floating level.
  always_comb begin
    oe_lo_meta_d = oe_lo_n_i;
    oe_lo_sync_d = oe_lo_meta_q;
    oe_hi_meta_d = oe_hi_n_i;
    oe_hi_sync_d = oe_hi_meta_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      oe_lo_meta_q <= `WBR_OE_N_OFF; // [R06]
      oe_lo_sync_q <= `WBR_OE_N_OFF;
      oe_hi_meta_q <= `WBR_OE_N_OFF;
      oe_hi_sync_q <= `WBR_OE_N_OFF;
    end else begin
      oe_lo_meta_q <= oe_lo_meta_d;
      oe_lo_sync_q <= oe_lo_sync_d;
      oe_hi_meta_q <= oe_hi_meta_d;
      oe_hi_sync_q <= oe_hi_sync_d;
    end
  end

  // The two halves share the clock but have their own enables. [R02]
  wide_bus_half u_half_lo (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .data_i    (data_sync_q[`WBR_HALF_W-1:0]),
    .oe_n_i    (oe_lo_sync_q),
    .q_o       (q_o[`WBR_HALF_W-1:0]),
    .q_oe_o    (q_oe_o[`WBR_HALF_W-1:0])
  );

  wide_bus_half u_half_hi (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .data_i    (data_sync_q[`WBR_DATA_W-1:`WBR_HI_LSB]),
    .oe_n_i    (oe_hi_sync_q),
    .q_o       (q_o[`WBR_DATA_W-1:`WBR_HI_LSB]),
    .q_oe_o    (q_oe_o[`WBR_DATA_W-1:`WBR_HI_LSB])
  );

  // Counts edges after reset until the pipeline holds real pin values.
  always_comb begin
    settle_d = settle_q;
    if (settle_q != `WBR_PIPE_DEPTH) begin
      settle_d = settle_q + `WBR_SETTLE_STEP;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      settle_q <= `WBR_SETTLE_ZERO;
    end else begin
      settle_q <= settle_d;
    end
  end

  assign settled = (settle_q == `WBR_PIPE_DEPTH);

  default clocking cb @(posedge sys_clk_i);
  endclocking

  default disable iff (!resetn_i);

  sequence s_lo_reenable;
    $rose(q_oe_o[0]);
  endsequence

  sequence s_hi_reenable;
    $rose(q_oe_o[`WBR_HI_LSB]);
  endsequence

  property p_load_full;
    settled |-> (q_o == $past(d_i, 3));
  endproperty
  a_load_full: assert property (p_load_full) // [R01]
    else $error("Stored word does not match input three edges back.");

  property p_halves_split;
    (settled && ($past(oe_lo_n_i, 3) != $past(oe_hi_n_i, 3)))
      |-> (q_oe_o[0] != q_oe_o[`WBR_HI_LSB]);
  endproperty
  a_halves_split: assert property (p_halves_split) // [R02]
    else $error("Halves did not follow their own enables.");

  property p_enable_lo;
    settled |-> (q_oe_o[`WBR_HALF_W-1:0]
                 == {`WBR_HALF_W{!$past(oe_lo_n_i, 3)}});
  endproperty
  a_enable_lo: assert property (p_enable_lo) // [R03]
    else $error("Lower half drive does not follow its enable.");

  property p_enable_hi;
    settled |-> (q_oe_o[`WBR_DATA_W-1:`WBR_HI_LSB]
                 == {`WBR_HALF_W{!$past(oe_hi_n_i, 3)}});
  endproperty
  a_enable_hi: assert property (p_enable_hi) // [R03]
    else $error("Upper half drive does not follow its enable.");

  property p_load_while_floating;
    (settled && $past(oe_lo_n_i, 3) && $past(oe_hi_n_i, 3))
      ##1 settled |-> (q_o == $past(d_i, 3));
  endproperty
  a_load_while_floating: assert property (p_load_while_floating) // [R04]
    else $error("Storage stopped loading while outputs floated.");

  property p_reenable_lo;
    (settled and s_lo_reenable)
      |-> (q_o[`WBR_HALF_W-1:0] == $past(d_i[`WBR_HALF_W-1:0], 3));
  endproperty
  a_reenable_lo: assert property (p_reenable_lo) // [R05]
    else $error("Lower half shows stale data after re-enable.");

  property p_reenable_hi;
    (settled and s_hi_reenable)
      |-> (q_o[`WBR_DATA_W-1:`WBR_HI_LSB]
           == $past(d_i[`WBR_DATA_W-1:`WBR_HI_LSB], 3));
  endproperty
  a_reenable_hi: assert property (p_reenable_hi) // [R05]
    else $error("Upper half shows stale data after re-enable.");

  property p_float_after_reset;
    $rose(resetn_i) |-> (q_oe_o == '0) [*3];
  endproperty
  a_float_after_reset: assert property (p_float_after_reset) // [R06]
    else $error("Outputs drove within three edges of reset release.");

  property p_load_in_reset;
    @(posedge sys_clk_i) disable iff (1'b0)
    (!resetn_i && !$past(resetn_i, 1) && !$past(resetn_i, 2)
     && !$past(resetn_i, 3)) |-> (q_o == $past(d_i, 3));
  endproperty
  a_load_in_reset: assert property (p_load_in_reset) // [R07]
    else $error("Reset disturbed the stored word.");

  property p_float_in_reset;
    @(posedge sys_clk_i) disable iff (1'b0)
    (!resetn_i && !$past(resetn_i, 1)) |-> (q_oe_o == '0);
  endproperty
  a_float_in_reset: assert property (p_float_in_reset) // [R06]
    else $error("Outputs drove while reset was held.");

  property p_drive_on_lo;
    $fell(oe_lo_n_i) |-> ##3 q_oe_o[0];
  endproperty
  a_drive_on_lo: assert property (p_drive_on_lo) // [R03]
    else $error("Lower half did not drive three edges after enable.");

  property p_drive_off_lo;
    $rose(oe_lo_n_i) |-> ##3 !q_oe_o[0];
  endproperty
  a_drive_off_lo: assert property (p_drive_off_lo) // [R03]
    else $error("Lower half did not float three edges after disable.");

  property p_drive_on_hi;
    $fell(oe_hi_n_i) |-> ##3 q_oe_o[`WBR_HI_LSB];
  endproperty
  a_drive_on_hi: assert property (p_drive_on_hi) // [R03]
    else $error("Upper half did not drive three edges after enable.");

  property p_drive_off_hi;
    $rose(oe_hi_n_i) |-> ##3 !q_oe_o[`WBR_HI_LSB];
  endproperty
  a_drive_off_hi: assert property (p_drive_off_hi) // [R03]
    else $error("Upper half did not float three edges after disable.");

  property p_halves_same;
    (settled && ($past(oe_lo_n_i, 3) == $past(oe_hi_n_i, 3)))
      |-> (q_oe_o[0] == q_oe_o[`WBR_HI_LSB]);
  endproperty
  a_halves_same: assert property (p_halves_same) // [R02]
    else $error("Halves with equal enables drove differently.");

endmodule

`default_nettype wire
